// ### rtl/sc_ctrl_map.vh
`ifndef SC_CTRL_MAP_VH
`define SC_CTRL_MAP_VH

// Register offsets on the 8-bit host bus.
`define OFS_CARD_CLOCK_STOP_CONTROL 8'h03
`define OFS_ETU_WIDTH_SELECT 8'h04
`define OFS_ETU_DIVIDER_CONSTANT 8'h05
`define OFS_RECEIVE_FIFO_CONTROL 8'h06
`define OFS_PARITY_RETRY_LIMITS 8'h07

// Clock stop control fields.
`define CSC_STOP_BIT 1
`define CSC_LEVEL_BIT 0

// Width select field.
`define EWS_WIDTH_BIT 0

// Receive FIFO control fields.
`define RFC_PURGE_BIT 7
`define RFC_THR_MSB 6
`define RFC_THR_LSB 4
`define RFC_COUNT_MSB 3
`define RFC_COUNT_LSB 0

// Parity and retry limit fields.
`define PRL_RETRY_CLR_BIT 7
`define PRL_RETRY_MSB 6
`define PRL_RETRY_LSB 4
`define PRL_PAR_CLR_BIT 3
`define PRL_PAR_MSB 2
`define PRL_PAR_LSB 0

// Reset values.
`define RST_CARD_CLOCK_STOP_CONTROL 2'h0
`define RST_ETU_WIDTH_SELECT 1'h0
`define RST_ETU_DIVIDER_CONSTANT 8'h0c
`define RST_FIFO_THRESHOLD 3'h0
`define RST_RETRY_LIMIT 3'h0
`define RST_PARITY_LIMIT 3'h0

// Timing counts.
`define ETU_LAST_NARROW 5'h1e
`define ETU_LAST_WIDE 5'h1f
`define RETRY_GAP_ETU 4'hf
`define RX_BUFFER_BYTES 5'h08
`define CLK_START_DELAY_CYCLES 200
`define CLK_STOP_DELAY_CYCLES 200

`endif

// ### rtl/rx_byte_fifo.v
`timescale 1ns/1ps
`default_nettype none

module rx_byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_sys, // System clock.
    input wire sys_rst, // Asynchronous reset, active high.
    input wire flush, // Empties the buffer.
    input wire in_valid, // Source offers a word.
    output wire in_ready, // Buffer can take a word.
    input wire [WIDTH-1:0] in_data, // Word offered.
    output wire out_valid, // A word is waiting.
    input wire out_ready, // Drain takes the word.
    output wire [WIDTH-1:0] out_data, // Oldest word.
    output reg [AW:0] count // Words held.
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH[AW:0]) && !flush;
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready && !flush;

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // rx_byte_fifo

`default_nettype wire

// ### rtl/card_clock_gen.v
`timescale 1ns/1ps
`default_nettype none

module card_clock_gen (
    input wire clk_sys, // System clock.
    input wire sys_rst, // Asynchronous reset, active high.
    input wire [7:0] divisor, // Half period in system cycles.
    input wire run, // Keep the card clock toggling.
    input wire park_high, // Level to hold when stopped.
    output reg card_clk, // Card clock to the pin.
    output wire clk_rise, // Pulse as the card clock rises.
    output wire parked // Clock is held at its park level.
);
    reg [7:0] cnt;
    wire [7:0] half;
    wire term;
    wire toggle;

    // A divisor of zero behaves as one.
    assign half = (divisor == 8'h00) ? 8'h01 : divisor;
    assign term = (cnt >= half - 8'h01);
    // A stop finishes the running half period, so no runt pulse reaches the card.
    assign toggle = run || (card_clk != park_high);
    assign clk_rise = term && toggle && !card_clk;
    assign parked = !run && (card_clk == park_high);

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 8'h00;
            card_clk <= 1'b0;
        end else if (term) begin
            cnt <= 8'h00;
            if (toggle) begin
                card_clk <= !card_clk;
            end
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // card_clock_gen

`default_nettype wire

// ### rtl/smartcard_clock_etu_fifo_ctrl.v
// Notes on behaviour
// - Unused upper control bits ignored, read zero.
// - Stop bit zero runs clock, start delay.
// - Stop bit one halts after character, delay.
// - Level bit parks stopped clock low/high.
// - ETU is 31 or 32 divider cycles.
// - Divider counts card clocks; zero acts one.
// - Divider resets to twelve, ETU 372.
// - Purge empties FIFO, clears error flags.
// - FIFO full at threshold plus one bytes.
// - T=0 forces full threshold to one.
// - Low bits read byte count capped at 8, writes ignored.
// - Retry clear bit resets retry counter.
// - T=0 retry field allows zero to seven.
// - Retransmit starts 15 ETU after NAK.
// - Retries exhausted raises retry interrupt.
// - Parity clear bit resets error counter.
// - T=0 parity limit N interrupts on error N+1.
// - Card clock is system clock over 2n.
`timescale 1ns/1ps
`default_nettype none
`include "sc_ctrl_map.vh"

module smartcard_clock_etu_fifo_ctrl #(
    parameter START_DELAY = `CLK_START_DELAY_CYCLES,
    parameter STOP_DELAY = `CLK_STOP_DELAY_CYCLES,
    parameter FIFO_DEPTH = 16
) (
    input wire clk_sys, // System clock, 50 MHz.
    input wire sys_rst, // Asynchronous reset, active high.
    input wire [7:0] paddr, // APB address.
    input wire psel, // APB select.
    input wire penable, // APB access phase.
    input wire pwrite, // APB write.
    input wire [7:0] pwdata, // APB write data.
    output reg [7:0] prdata, // APB read data.
    output wire pready, // APB ready, always high.
    output wire pslverr, // APB error on unmapped address.
    input wire [7:0] clk_divisor, // Card clock half period.
    input wire t0_mode, // Protocol T=0 selected.
    input wire char_active, // A character is being sent or received.
    output wire card_clk, // Card clock pin.
    output wire card_clk_parked, // Card clock is stopped.
    output wire char_enable, // A new character may start.
    output reg etu_tick, // One-cycle ETU boundary pulse.
    input wire rx_valid, // Received byte offered.
    input wire [7:0] rx_data, // Received byte.
    output wire rx_ready, // Buffer takes the byte.
    output wire buf_valid, // Buffered byte waiting.
    output wire [7:0] buf_data, // Oldest buffered byte.
    input wire buf_ready, // Host reader takes the byte.
    output wire fifo_full, // Fill level above threshold.
    input wire rx_parity_err, // Pulse: received parity error.
    output reg parity_err_flag, // Sticky parity error status.
    output reg overrun_flag, // Sticky overrun status.
    input wire tx_nak, // Pulse: card NAKed a character.
    output reg retransmit_go, // Pulse: start the retransmission.
    output reg retry_irq, // Pulse: retries used up.
    output reg parity_irq // Pulse: parity error limit reached.
);
    localparam CS_RUN = 4'b0001;
    localparam CS_DRAIN = 4'b0010;
    localparam CS_HALT = 4'b0100;
    localparam CS_WAKE = 4'b1000;
    reg stop_req, park_high, etu_wide, retry_wait;
    reg [7:0] etu_div, div_cnt;
    reg [2:0] fifo_thr, retry_lim, par_lim, retry_cnt;
    reg [3:0] clk_state, next_clk_state, gap_cnt, par_cnt;
    reg [15:0] delay_cnt;
    reg [4:0] width_cnt;
    wire wr_en, rd_setup, clk_rise, div_term, purge, retry_clr, par_clr, rx_reject;
    wire [4:0] fifo_count, width_last;
    wire [3:0] count_shown, par_base;
    wire [2:0] thr_eff, retry_base;
    wire [7:0] etu_mod;
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `OFS_CARD_CLOCK_STOP_CONTROL) || (a == `OFS_ETU_WIDTH_SELECT) ||
                     (a == `OFS_ETU_DIVIDER_CONSTANT) || (a == `OFS_RECEIVE_FIFO_CONTROL) ||
                     (a == `OFS_PARITY_RETRY_LIMITS);
        end
    endfunction
    function write_to;
        input [7:0] a;
        input [7:0] ofs;
        begin
            write_to = wr_en && (a == ofs);
        end
    endfunction
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    // Host register writes.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            {stop_req, park_high} <= `RST_CARD_CLOCK_STOP_CONTROL;
            etu_wide <= `RST_ETU_WIDTH_SELECT;
            etu_div <= `RST_ETU_DIVIDER_CONSTANT;
            fifo_thr <= `RST_FIFO_THRESHOLD;
            retry_lim <= `RST_RETRY_LIMIT;
            par_lim <= `RST_PARITY_LIMIT;
        end else begin
            if (write_to(paddr, `OFS_CARD_CLOCK_STOP_CONTROL)) begin
                stop_req <= pwdata[`CSC_STOP_BIT];
                park_high <= pwdata[`CSC_LEVEL_BIT];
            end
            if (write_to(paddr, `OFS_ETU_WIDTH_SELECT))
                etu_wide <= pwdata[`EWS_WIDTH_BIT];
            if (write_to(paddr, `OFS_ETU_DIVIDER_CONSTANT))
                etu_div <= pwdata;
            if (write_to(paddr, `OFS_RECEIVE_FIFO_CONTROL))
                fifo_thr <= pwdata[`RFC_THR_MSB:`RFC_THR_LSB];
            if (write_to(paddr, `OFS_PARITY_RETRY_LIMITS)) begin
                retry_lim <= pwdata[`PRL_RETRY_MSB:`PRL_RETRY_LSB];
                par_lim <= pwdata[`PRL_PAR_MSB:`PRL_PAR_LSB];
            end
        end
    end

    assign count_shown = (fifo_count > `RX_BUFFER_BYTES) ? 4'h8 : fifo_count[3:0];

    // Read data is latched in the setup phase so it is stable through the access phase.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 8'h00;
        end else if (rd_setup) begin
            case (paddr)
                `OFS_CARD_CLOCK_STOP_CONTROL: prdata <= {6'h00, stop_req, park_high};
                `OFS_ETU_WIDTH_SELECT: prdata <= {7'h00, etu_wide};
                `OFS_ETU_DIVIDER_CONSTANT: prdata <= etu_div;
                `OFS_RECEIVE_FIFO_CONTROL: prdata <= {1'b0, fifo_thr, count_shown};
                `OFS_PARITY_RETRY_LIMITS: prdata <= {1'b0, retry_lim, 1'b0, par_lim};
                default: prdata <= 8'h00;
            endcase
        end
    end

    card_clock_gen u_clk (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .divisor(clk_divisor),
        .run(clk_state != CS_HALT),
        .park_high(park_high),
        .card_clk(card_clk),
        .clk_rise(clk_rise),
        .parked(card_clk_parked)
    );

    // Clock stop and restart sequencing.
    always @* begin
        next_clk_state = clk_state;
        case (clk_state)
            CS_RUN: begin
                if (stop_req) begin
                    next_clk_state = CS_DRAIN;
                end
            end
            CS_DRAIN: begin
                if (!stop_req) begin
                    next_clk_state = CS_RUN;
                end else if (!char_active && clk_rise && delay_cnt >= STOP_DELAY - 1) begin
                    next_clk_state = CS_HALT;
                end
            end
            CS_HALT: begin
                if (!stop_req) begin
                    next_clk_state = CS_WAKE;
                end
            end
            CS_WAKE: begin
                if (stop_req) begin
                    next_clk_state = CS_HALT;
                end else if (clk_rise && delay_cnt >= START_DELAY - 1) begin
                    next_clk_state = CS_RUN;
                end
            end
            default: next_clk_state = CS_RUN;
        endcase
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            clk_state <= CS_RUN;
            delay_cnt <= 16'h0000;
        end else begin
            clk_state <= next_clk_state;
            // A character in flight restarts the stop delay, so the bit may be set mid-character.
            if (next_clk_state != clk_state || char_active) begin
                delay_cnt <= 16'h0000;
            end else if (clk_rise) begin
                delay_cnt <= delay_cnt + 16'h0001;
            end
        end
    end

    assign char_enable = (clk_state == CS_RUN) || (clk_state == CS_DRAIN);

    assign etu_mod = (etu_div == 8'h00) ? 8'h01 : etu_div;
    assign div_term = clk_rise && (div_cnt >= etu_mod - 8'h01);
    assign width_last = etu_wide ? `ETU_LAST_WIDE : `ETU_LAST_NARROW;

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt <= 8'h00;
            width_cnt <= 5'h00;
            etu_tick <= 1'b0;
        end else begin
            etu_tick <= 1'b0;
            if (div_term) begin
                div_cnt <= 8'h00;
                if (width_cnt >= width_last) begin
                    width_cnt <= 5'h00;
                    etu_tick <= 1'b1;
                end else begin
                    width_cnt <= width_cnt + 5'h01;
                end
            end else if (clk_rise) begin
                div_cnt <= div_cnt + 8'h01;
            end
        end
    end

    assign purge = write_to(paddr, `OFS_RECEIVE_FIFO_CONTROL) && pwdata[`RFC_PURGE_BIT];

    rx_byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .flush(purge),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data(rx_data),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data),
        .count(fifo_count)
    );

    assign thr_eff = t0_mode ? 3'h0 : fifo_thr;
    assign fifo_full = (fifo_count >= {2'h0, thr_eff} + 5'h01);

    assign rx_reject = rx_valid && !rx_ready;

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            parity_err_flag <= 1'b0;
            overrun_flag <= 1'b0;
        end else begin
            // A new event in the purge cycle is kept.
            parity_err_flag <= rx_parity_err || (parity_err_flag && !purge);
            overrun_flag <= rx_reject || (overrun_flag && !purge);
        end
    end

    assign retry_clr = write_to(paddr, `OFS_PARITY_RETRY_LIMITS) && pwdata[`PRL_RETRY_CLR_BIT];
    assign par_clr = write_to(paddr, `OFS_PARITY_RETRY_LIMITS) && pwdata[`PRL_PAR_CLR_BIT];
    assign retry_base = retry_clr ? 3'h0 : retry_cnt;
    assign par_base = par_clr ? 4'h0 : par_cnt;

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            retry_cnt <= 3'h0;
            retry_wait <= 1'b0;
            gap_cnt <= 4'h0;
            retransmit_go <= 1'b0;
            retry_irq <= 1'b0;
        end else begin
            retransmit_go <= 1'b0;
            retry_irq <= 1'b0;
            retry_cnt <= retry_base;
            if (tx_nak && t0_mode) begin
                if (retry_base < retry_lim) begin
                    retry_cnt <= retry_base + 3'h1;
                    retry_wait <= 1'b1;
                    gap_cnt <= 4'h0;
                end else begin
                    retry_irq <= 1'b1;
                end
            end else if (retry_wait && etu_tick) begin
                if (gap_cnt == `RETRY_GAP_ETU - 4'h1) begin
                    retry_wait <= 1'b0;
                    retransmit_go <= 1'b1;
                end else begin
                    gap_cnt <= gap_cnt + 4'h1;
                end
            end
        end
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            par_cnt <= 4'h0;
            parity_irq <= 1'b0;
        end else begin
            parity_irq <= 1'b0;
            par_cnt <= par_base;
            if (rx_parity_err && t0_mode) begin
                if (par_base == {1'b0, par_lim}) begin
                    parity_irq <= 1'b1;
                end
                if (par_base != 4'h8) begin
                    par_cnt <= par_base + 4'h1;
                end
            end
        end
    end
endmodule // smartcard_clock_etu_fifo_ctrl

`default_nettype wire

// ### bench/sc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sc_ctrl_asserts (
    input wire logic clk_sys, // Clock.
    input wire logic sys_rst, // Reset.
    input wire logic [7:0] paddr, // Address.
    input wire logic psel, // Select.
    input wire logic penable, // Access.
    input wire logic pwrite, // Write.
    input wire logic [7:0] pwdata, // Write data.
    input wire logic [7:0] prdata, // Read data.
    input wire logic [7:0] clk_divisor, // Half period.
    input wire logic t0_mode, // T=0.
    input wire logic rx_valid, // Byte in.
    input wire logic rx_parity_err, // Parity pulse.
    input wire logic tx_nak, // NAK pulse.
    input wire logic card_clk, // Card clock.
    input wire logic card_clk_parked, // Stopped.
    input wire logic etu_tick, // ETU pulse.
    input wire logic buf_valid, // Byte waiting.
    input wire logic fifo_full, // Full.
    input wire logic parity_err_flag, // Parity flag.
    input wire logic overrun_flag, // Overrun flag.
    input wire logic retry_irq, // Retries used.
    input wire logic parity_irq // Parity limit.
);
    logic park_high;
    wire rd_setup = psel && !penable && !pwrite;
    wire wr_acc = psel && penable && pwrite;
    // The park level is not a port, so it is shadowed from host writes.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) park_high <= 1'b0;
        else if (wr_acc && paddr == 8'h03) park_high <= pwdata[0];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    clk_ctrl_zero_a: assert property (rd_setup && paddr == 8'h03 |=> prdata[7:2] == 6'h00)
        else $error("clock control upper bits not zero");
    width_sel_zero_a: assert property (rd_setup && paddr == 8'h04 |=> prdata[7:1] == 7'h00)
        else $error("width select upper bits not zero");
    count_range_a: assert property (rd_setup && paddr == 8'h06 |=> prdata[3:0] <= 4'h8 && !prdata[7])
        else $error("byte count out of range");
    park_level_a: assert property (card_clk_parked |-> card_clk == park_high)
        else $error("card clock parked at wrong level");
    clk_half_a: assert property ($changed(card_clk) && clk_divisor == 8'h01 && !card_clk_parked
        |=> $changed(card_clk) || card_clk_parked) else $error("card clock half period wrong");
    tick_pulse_a: assert property (etu_tick |=> !etu_tick [*8])
        else $error("etu tick too long or too close");
    t0_threshold_a: assert property (t0_mode && buf_valid |-> fifo_full)
        else $error("full not forced to one byte");
    purge_clear_a: assert property (wr_acc && paddr == 8'h06 && pwdata[7] && !rx_valid && !rx_parity_err
        |=> !buf_valid && !parity_err_flag && !overrun_flag) else $error("purge left data or flags");
    parity_cause_a: assert property (parity_irq |-> $past(rx_parity_err) && $past(t0_mode))
        else $error("parity interrupt without cause");
    retry_cause_a: assert property (retry_irq |-> $past(tx_nak) && $past(t0_mode))
        else $error("retry interrupt without cause");
endmodule // sc_ctrl_asserts
`default_nettype wire

// ### bench/sc_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module sc_card_model (
    input wire logic clk_sys, // Clock.
    input wire logic rx_ready, // Buffer takes a byte.
    output logic char_active, // Character in flight.
    output logic rx_valid, // Byte offered.
    output logic [7:0] rx_data, // Byte value.
    output logic rx_parity_err, // Parity pulse.
    output logic tx_nak // NAK pulse.
);
    initial begin
        char_active = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_parity_err = 1'b0;
        tx_nak = 1'b0;
    end
    // A line receiver cannot wait, so each byte is offered for one cycle and a full buffer loses it.
    task automatic burst(input logic [7:0] d0, input int cnt, input int gap);
        for (int k = 0; k < cnt; k++) begin
            rx_valid <= 1'b1;
            rx_data <= d0 + k[7:0];
            @(posedge clk_sys);
            if (gap > 0 || k == cnt - 1) begin
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
                repeat (gap + 1) @(posedge clk_sys);
            end
        end
    endtask
    task automatic strobe(input logic nak);
        if (nak) tx_nak <= 1'b1;
        else rx_parity_err <= 1'b1;
        @(posedge clk_sys);
        tx_nak <= 1'b0;
        rx_parity_err <= 1'b0;
    endtask
    task automatic hold(input logic v);
        char_active <= v;
        @(posedge clk_sys);
    endtask
endmodule // sc_card_model
`default_nettype wire

// ### bench/smartcard_clock_etu_fifo_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module smartcard_clock_etu_fifo_ctrl_tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, t0_mode = 1'b0, buf_ready = 1'b0;
    logic [7:0] paddr = 8'h00, pwdata = 8'h00, clk_divisor = 8'h01, rd;
    logic [1:0] rsp;
    logic [7:0] etu_div_t [4] = '{8'h0c, 8'h00, 8'h01, 8'h03};
    logic [7:0] card_div_t [4] = '{8'h01, 8'h00, 8'h02, 8'h01};
    wire [7:0] prdata, rx_data, buf_data;
    wire pready, pslverr, card_clk, card_clk_parked, char_enable, etu_tick, rx_ready, buf_valid, fifo_full;
    wire parity_err_flag, overrun_flag, retransmit_go, retry_irq, parity_irq;
    wire char_active, rx_valid, rx_parity_err, tx_nak;
    int n_fail = 0;
    int comparisons = 0;
    int i, n, m, t;
    always #10 clk_sys = ~clk_sys;
    // Short start and stop delays keep the clock stop tests brief.
    smartcard_clock_etu_fifo_ctrl #(.START_DELAY(2), .STOP_DELAY(2))
        u_smartcard_clock_etu_fifo_ctrl (.*);
    sc_card_model u_sc_card_model (.*);
    task automatic chk(input string nm, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys) penable <= 1'b1;
        @(posedge clk_sys) rd = prdata;
        rsp = {pready, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, e);
        bus(1'b0, a, 8'h00);
        chk(nm, rd, e);
        chk("bus_response", rsp, {1'b1, a < 8'h03 || a > 8'h07});
    endtask
    task automatic wait_park();
        for (i = 0; i < 100 && !card_clk_parked; i++) @(posedge clk_sys);
        chk("parked", card_clk_parked, 1'b1);
    endtask
    task automatic wait_run();
        for (i = 0; i < 100 && !char_enable; i++) @(posedge clk_sys);
        chk("running", char_enable, 1'b1);
    endtask
    task automatic etu_len(output int c);
        for (i = 0; i < 3000 && !etu_tick; i++) @(posedge clk_sys);
        @(posedge clk_sys);
        for (c = 1; c < 3000 && !etu_tick; c++) @(posedge clk_sys);
    endtask
    task automatic nak(output int c);
        u_sc_card_model.strobe(1'b1);
        c = 0;
        for (i = 0; i < 2000 && !retransmit_go && !retry_irq; i++) begin
            @(posedge clk_sys);
            c += etu_tick;
        end
    endtask
    task automatic test_done;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (n = 3; n < 8; n++) rdc("reset_value", n[7:0], n == 5 ? 8'h0c : 8'h00);
        rdc("unmapped", 8'h20, 8'h00);
        // One ETU lasts twice the card divisor times the ETU divider times the width, in system cycles.
        for (n = 0; n < 4; n++) begin
            clk_divisor <= card_div_t[n];
            if (n > 0) wr(8'h05, etu_div_t[n]);
            wr(8'h04, {7'h7f, n[0]});
            rdc("etu_width", 8'h04, {7'h00, n[0]});
            etu_len(t);
            etu_len(t);
            m = 2 * (card_div_t[n] == 8'h00 ? 1 : card_div_t[n]);
            chk("etu_cycles", t[15:0], m * (etu_div_t[n] == 8'h00 ? 1 : etu_div_t[n]) * (31 + n % 2));
        end
        wr(8'h05, 8'h01);
        u_sc_card_model.hold(1'b1);
        wr(8'h03, 8'hff);
        repeat (20) @(posedge clk_sys);
        chk("parked_in_char", card_clk_parked, 1'b0);
        rdc("clock_ctrl", 8'h03, 8'h03);
        u_sc_card_model.hold(1'b0);
        wait_park();
        chk("park_high", card_clk, 1'b1);
        wr(8'h03, 8'h01);
        chk("start_delay", char_enable, 1'b0);
        wait_run();
        wr(8'h03, 8'h02);
        wait_park();
        chk("park_low", card_clk, 1'b0);
        wr(8'h03, 8'h00);
        wait_run();
        u_sc_card_model.burst(8'h40, 17, 0);
        rdc("fill_count", 8'h06, 8'h08);
        chk("overrun", overrun_flag, 1'b1);
        chk("rx_ready_full", rx_ready, 1'b0);
        for (n = 0; n < 16; n++) begin
            chk("drain_data", buf_data, 8'h40 + n[7:0]);
            buf_ready <= 1'b1;
            @(posedge clk_sys);
            buf_ready <= 1'b0;
            @(posedge clk_sys);
        end
        chk("drained", buf_valid, 1'b0);
        u_sc_card_model.burst(8'h10, 3, 0);
        wr(8'h06, 8'h80);
        chk("purge_overrun", overrun_flag, 1'b0);
        rdc("purge_count", 8'h06, 8'h00);
        for (n = 0; n < 8; n++) begin
            wr(8'h06, {1'b0, n[2:0], 4'h5});
            u_sc_card_model.burst(8'h00, n, 2);
            chk("below_thr", fifo_full, 1'b0);
            u_sc_card_model.burst(8'h00, 1, 0);
            chk("at_thr", fifo_full, 1'b1);
            wr(8'h06, {1'b1, n[2:0], 4'h0});
        end
        t0_mode <= 1'b1;
        u_sc_card_model.burst(8'h00, 1, 0);
        chk("t0_thr", fifo_full, 1'b1);
        rdc("t0_count", 8'h06, 8'h71);
        wr(8'h06, 8'hf0);
        wr(8'h07, 8'h20);
        for (n = 0; n < 3; n++) begin
            nak(t);
            chk("retx_kind", {retransmit_go, retry_irq}, n < 2 ? 2'h2 : 2'h1);
            if (n < 2) chk("retx_gap", t[15:0], 16'h000f);
        end
        wr(8'h07, 8'ha0);
        nak(t);
        chk("after_clear", retransmit_go, 1'b1);
        wr(8'h07, 8'h80);
        nak(t);
        chk("no_retry", retry_irq, 1'b1);
        for (m = 0; m < 2; m++) begin
            wr(8'h07, 8'h0a);
            for (n = 0; n < 3; n++) begin
                u_sc_card_model.strobe(1'b0);
                @(posedge clk_sys);
                chk("parity_irq", parity_irq, n == 2);
            end
        end
        chk("parity_flag", parity_err_flag, 1'b1);
        wr(8'h06, 8'hf0);
        chk("purge_parity", parity_err_flag, 1'b0);
        test_done;
    end
endmodule // smartcard_clock_etu_fifo_ctrl_tb_top
bind smartcard_clock_etu_fifo_ctrl sc_ctrl_asserts u_sc_ctrl_asserts (.*);
`default_nettype wire
